// file: include/iadec_pkg.sv
package iadec_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int FLASH_W = 14;
  localparam int FLASH_AW = 15;
  localparam int EE_AW = 8;
  localparam int DM_AW = 12;
  localparam logic [15:0] BANKED_LO = 16'h0000;
  localparam logic [15:0] BANKED_HI = 16'h0fff;
  localparam logic [15:0] LINEAR_LO = 16'h2000;
  localparam logic [15:0] LINEAR_HI = 16'h29af;
  localparam logic [15:0] EE_LO = 16'h7000;
  localparam logic [15:0] EE_HI = 16'h70ff;
  localparam int FLASH_SEL_BIT = 15;
  localparam logic [6:0] GPR_BYTES = 7'h50;
  localparam logic [6:0] GPR_BASE = 7'h20;
  localparam logic [6:0] BANK_SPAN = 7'h7f;
  localparam logic [11:0] WIN0_ADDR = 12'h000;
  localparam logic [11:0] WIN1_ADDR = 12'h001;
  localparam int NVM_EXTRA_CYC = 1;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0]
  {
    IADEC_RGN_NONE = 3'h0,
    IADEC_RGN_BANKED = 3'h1,
    IADEC_RGN_LINEAR = 3'h2,
    IADEC_RGN_FLASH = 3'h3,
    IADEC_RGN_EE = 3'h4,
    IADEC_RGN_WIN = 3'h5
  } iadec_rgn_t;

  typedef struct packed
  {
    logic [7:0] high;
    logic [7:0] low;
  } iadec_ptr_t;

  typedef struct packed
  {
    iadec_rgn_t rgn;
    logic [11:0] dm_addr;
    logic [14:0] flash_addr;
    logic [7:0] ee_addr;
    logic wr_ok;
  } iadec_map_t;
endpackage

// file: core/iadec_linmap.sv
`timescale 1ns/10ps
module iadec_linmap #(
  parameter int NUM_BANKS = 32
) (
  input wire logic [15:0] ptr,
  output logic [11:0] dm_addr,
  output logic hit
);
  logic [11:0] off;
  logic [6:0] bank;
  logic [6:0] rem;
  always_comb
  begin
    off = ptr[11:0] - iadec_pkg::LINEAR_LO[11:0];
    bank = 7'(off / 12'(iadec_pkg::GPR_BYTES));
    rem = 7'(off % 12'(iadec_pkg::GPR_BYTES));
    // common bytes never reached: rem stays below the 80-byte block
    dm_addr = {bank[4:0], 7'(iadec_pkg::GPR_BASE + rem)};
    hit = (ptr >= iadec_pkg::LINEAR_LO) && (ptr <= iadec_pkg::LINEAR_HI)
      && (32'(bank) < NUM_BANKS);
  end
endmodule // iadec_linmap

// file: core/iadec_region.sv
`timescale 1ns/10ps
module iadec_region #(
  parameter int NUM_BANKS = 32
) (
  input wire iadec_pkg::iadec_ptr_t ptr,
  output iadec_pkg::iadec_map_t map
);
  logic [15:0] addr;
  logic [11:0] lin_addr;
  logic lin_hit;
  assign addr = {ptr.high, ptr.low};
  iadec_linmap #(
    .NUM_BANKS(NUM_BANKS)
  ) u_lin (
    .ptr(addr),
    .dm_addr(lin_addr),
    .hit(lin_hit)
  );
  always_comb
  begin
    map.rgn = iadec_pkg::IADEC_RGN_NONE;
    map.dm_addr = addr[11:0];
    map.flash_addr = addr[14:0];
    map.ee_addr = ptr.low;
    map.wr_ok = 1'b0;
    if (addr[iadec_pkg::FLASH_SEL_BIT])
      map.rgn = iadec_pkg::IADEC_RGN_FLASH;
    else if (addr >= iadec_pkg::EE_LO && addr <= iadec_pkg::EE_HI)
      map.rgn = iadec_pkg::IADEC_RGN_EE;
    else if (lin_hit)
    begin
      map.rgn = iadec_pkg::IADEC_RGN_LINEAR;
      map.dm_addr = lin_addr;
      map.wr_ok = 1'b1;
    end
    else if (addr <= iadec_pkg::BANKED_HI)
    begin
      map.rgn = iadec_pkg::IADEC_RGN_BANKED;
      map.wr_ok = 1'b1;
    end
    if (map.rgn inside {iadec_pkg::IADEC_RGN_BANKED,
      iadec_pkg::IADEC_RGN_LINEAR} &&
      ((map.dm_addr[6:0] == iadec_pkg::WIN0_ADDR[6:0]) ||
      (map.dm_addr[6:0] == iadec_pkg::WIN1_ADDR[6:0])))
    begin
      map.rgn = iadec_pkg::IADEC_RGN_WIN;
      map.wr_ok = 1'b0;
    end
  end
endmodule // iadec_region

// file: core/iadec_top.sv
`timescale 1ns/10ps
module iadec_top #(
  parameter int NUM_BANKS = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req,
  input wire logic req_we,
  input wire logic req_sel,
  input wire iadec_pkg::iadec_ptr_t ptr0,
  input wire iadec_pkg::iadec_ptr_t ptr1,
  input wire logic [7:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic dm_re,
  output logic dm_we,
  output logic [11:0] dm_addr,
  output logic [7:0] dm_wdata,
  input wire logic [7:0] dm_rdata,
  output logic fl_re,
  output logic [14:0] fl_addr,
  input wire logic [13:0] fl_rdata,
  output logic ee_re,
  output logic [7:0] ee_addr,
  input wire logic [7:0] ee_rdata
);
  typedef enum logic [1:0]
  {
    IADEC_IDLE = 2'b00,
    IADEC_WAIT = 2'b01,
    IADEC_DONE = 2'b11
  } iadec_st_t;

  iadec_pkg::iadec_ptr_t ptr;
  iadec_pkg::iadec_map_t map;
  iadec_st_t st_q, st_d;
  iadec_pkg::iadec_rgn_t rgn_q, rgn_d;
  logic [7:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic nvm;

  assign ptr = req_sel ? ptr1 : ptr0;

  iadec_region #(
    .NUM_BANKS(NUM_BANKS)
  ) u_rgn (
    .ptr(ptr),
    .map(map)
  );

  assign nvm = (map.rgn == iadec_pkg::IADEC_RGN_FLASH) ||
    (map.rgn == iadec_pkg::IADEC_RGN_EE);

  // target strobes are combinational off the live request
  always_comb
  begin
    dm_addr = map.dm_addr;
    fl_addr = map.flash_addr;
    ee_addr = map.ee_addr;
    dm_wdata = req_wdata;
    dm_re = 1'b0;
    dm_we = 1'b0;
    fl_re = 1'b0;
    ee_re = 1'b0;
    if (req && st_q == IADEC_IDLE)
    begin
      dm_we = req_we && map.wr_ok;
      dm_re = !req_we && map.wr_ok;
      fl_re = !req_we && (map.rgn == iadec_pkg::IADEC_RGN_FLASH);
      ee_re = !req_we && (map.rgn == iadec_pkg::IADEC_RGN_EE);
    end
  end

  // read data pick, zero for anything not implemented
  always_comb
  begin
    st_d = st_q;
    rgn_d = rgn_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    unique case (st_q)
      IADEC_IDLE:
      begin
        if (req)
        begin
          rgn_d = map.rgn;
          if (!req_we && nvm)
            st_d = IADEC_WAIT;
          else
          begin
            done_d = 1'b1;
            if (req_we)
              rdata_d = rdata_q;
            else if (map.wr_ok)
              rdata_d = dm_rdata;
            else
              rdata_d = iadec_pkg::ZERO_BYTE;
          end
        end
      end
      IADEC_WAIT:
      begin
        // first of two extra cycles for the nonvolatile read
        st_d = IADEC_DONE;
      end
      IADEC_DONE:
      begin
        st_d = IADEC_IDLE;
        done_d = 1'b1;
        if (rgn_q == iadec_pkg::IADEC_RGN_FLASH)
          rdata_d = fl_rdata[7:0];
        else
          rdata_d = ee_rdata;
      end
      default:
      begin
        st_d = IADEC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= IADEC_IDLE;
      rgn_q <= iadec_pkg::IADEC_RGN_NONE;
      rdata_q <= iadec_pkg::ZERO_BYTE;
      done_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      rgn_q <= rgn_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
    end
  end

  assign busy = (st_q != IADEC_IDLE);
  assign done = done_q;
  assign rdata = rdata_q;
endmodule // iadec_top

// file: tb/iadec_asserts.sv
`timescale 1ns/10ps
module iadec_asserts #(
  parameter int NUM_BANKS = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req,
  input wire logic req_we,
  input wire logic req_sel,
  input wire iadec_pkg::iadec_ptr_t ptr0,
  input wire iadec_pkg::iadec_ptr_t ptr1,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] rdata,
  input wire logic dm_re,
  input wire logic dm_we,
  input wire logic [11:0] dm_addr,
  input wire logic [7:0] dm_rdata,
  input wire logic fl_re,
  input wire logic [14:0] fl_addr,
  input wire logic [13:0] fl_rdata,
  input wire logic ee_re,
  input wire logic [7:0] ee_addr,
  input wire logic [7:0] ee_rdata
);
  logic [15:0] pa;
  logic [15:0] ln;
  logic a;
  assign pa = req_sel ? ptr1 : ptr0;
  assign ln = pa - 16'h2000;
  assign a = req && !busy;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  flash_map_a: assert property (a && pa[15] && !req_we |->
    fl_re && fl_addr == pa[14:0]) else $error("flash map");
  flash_data_a: assert property (fl_re |-> ##1 busy [*2] ##1
    done && rdata == $past(fl_rdata[7:0])) else $error("flash data");
  ee_map_a: assert property (a && pa[15:8] == 8'h70 && !req_we |->
    ee_re && ee_addr == pa[7:0]) else $error("ee map");
  ee_data_a: assert property (ee_re |-> ##1 busy [*2] ##1
    done && rdata == $past(ee_rdata)) else $error("ee data");
  banked_rd_a: assert property (a && !req_we && pa[15:12] == 4'h0
    && pa[6:1] != 6'h0 |-> dm_re && dm_addr == pa[11:0] ##1
    done && rdata == $past(dm_rdata)) else $error("banked read");
  window_a: assert property (a && pa[15:12] == 4'h0 && pa[6:1] == 6'h0
    |-> !dm_we ##1 done && ($past(req_we) || rdata == 8'h00))
    else $error("window");
  nvm_wr_a: assert property (a && req_we && (pa[15] ||
    pa[15:8] == 8'h70) |-> !dm_we && !fl_re && !ee_re ##1 done)
    else $error("nvm write");
  linear_a: assert property (a && pa >= 16'h2000 &&
    pa <= 16'h29af |-> (dm_re || dm_we) && dm_addr ==
    {5'(ln / 16'd80), 7'(7'h20 + ln % 16'd80)}) else $error("linear");
endmodule // iadec_asserts
bind iadec_top iadec_asserts #(.NUM_BANKS(NUM_BANKS)) u_chk (.*);

// file: tb/iadec_mem_model.sv
`timescale 1ns/10ps
module iadec_mem_model (
  input wire logic clk,
  input wire logic dm_we,
  input wire logic [11:0] dm_addr,
  input wire logic [7:0] dm_wdata,
  output logic [7:0] dm_rdata,
  input wire logic fl_re,
  input wire logic [14:0] fl_addr,
  output logic [13:0] fl_rdata,
  input wire logic ee_re,
  input wire logic [7:0] ee_addr,
  output logic [7:0] ee_rdata
);
  logic [7:0] ram [4096];
  logic [1:0] c = 2'h0;
  logic [14:0] na = 15'h0;
  initial for (int i = 0; i < 4096; i++) ram[i] = 8'h00;
  assign dm_rdata = ram[dm_addr];
  // nvm data valid two and three cycles after the strobe, scrambled otherwise
  assign fl_rdata = c[1] ? na[13:0] ^ 14'h2a5a : ~(na[13:0] ^ 14'h2a5a);
  assign ee_rdata = c[1] ? na[7:0] ^ 8'h3c : ~(na[7:0] ^ 8'h3c);
  always @(posedge clk)
  begin
    if (dm_we) ram[dm_addr] <= dm_wdata;
    c <= (fl_re || ee_re) ? 2'h1 : c + {1'b0, c != 2'h0};
    if (fl_re) na <= fl_addr;
    if (ee_re) na <= {7'h0, ee_addr};
  end
endmodule // iadec_mem_model

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic req = 1'b0;
  logic req_we = 1'b0;
  logic req_sel = 1'b0;
  iadec_pkg::iadec_ptr_t ptr0 = '0;
  iadec_pkg::iadec_ptr_t ptr1 = '0;
  logic [7:0] req_wdata = 8'h00;
  logic busy, done, dm_re, dm_we, fl_re, ee_re;
  logic [7:0] rdata, dm_wdata, dm_rdata, ee_addr, ee_rdata;
  logic [11:0] dm_addr;
  logic [14:0] fl_addr;
  logic [13:0] fl_rdata;
  logic [7:0] r;
  int error_cnt = 0;
  int num_checks = 0;
  always #4 clk = ~clk;
  iadec_top #(.NUM_BANKS(32)) DUT (.*);
  iadec_mem_model u_mem (.*);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp);
    num_checks++;
    if (r !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, r, exp);
    end
  endtask
  task automatic acc(input logic s, input logic w, input logic [15:0] p,
    input logic [7:0] d);
    int n;
    @(negedge clk);
    req = 1'b1;
    req_we = w;
    req_sel = s;
    req_wdata = d;
    if (s) ptr1 = p;
    else ptr0 = p;
    @(negedge clk);
    req = 1'b0;
    for (n = 0; n < 6 && done !== 1'b1; n++) @(negedge clk);
    if (n == 6)
    begin
      error_cnt++;
      finish_test();
    end
    r = rdata;
  endtask
  task automatic t_ram();
    acc(0, 1, 16'h0055, 8'ha5);
    acc(1, 0, 16'h0055, 8'h00);
    chk(8'ha5);
    acc(0, 1, 16'h0080, 8'h77);
    acc(1, 0, 16'h0080, 8'h00);
    chk(8'h00);
    $display("t_ram done");
  endtask
  task automatic t_lin();
    acc(0, 1, 16'h0f6f, 8'h5c);
    acc(1, 0, 16'h29af, 8'h00);
    chk(8'h5c);
    acc(0, 1, 16'h2050, 8'h3c);
    acc(0, 0, 16'h00a0, 8'h00);
    chk(8'h3c);
    acc(1, 1, 16'h204f, 8'h4f);
    acc(0, 0, 16'h006f, 8'h00);
    chk(8'h4f);
    $display("t_lin done");
  endtask
  task automatic t_nvm();
    acc(0, 1, 16'hf042, 8'h11);
    acc(0, 0, 16'hf042, 8'h00);
    chk(8'h18);
    acc(1, 1, 16'h7042, 8'h22);
    acc(1, 0, 16'h7042, 8'h00);
    chk(8'h7e);
    $display("t_nvm done");
  endtask
  task automatic t_unmap();
    acc(0, 0, 16'h29b0, 8'h00);
    chk(8'h00);
    acc(1, 0, 16'h7100, 8'h00);
    chk(8'h00);
    $display("t_unmap done");
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    t_ram();
    t_lin();
    t_nvm();
    t_unmap();
    finish_test();
  end
endmodule // tb
